// [ioc_host.sv]
// Purpose: host processor model issuing i/o port cycles
// Assumes: strobes one cycle long, driven on the falling edge
// Notes:   idle address and data lines carry inverted junk, not the last value
`timescale 1ns/1ns
`default_nettype none
module ioc_host (
    input  wire logic        sys_clk_i,
    input  wire logic [7:0]  io_rdata_i,
    input  wire logic        io_rdata_valid_i,
    output logic      [15:0] io_addr_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_wdata_o,
    output logic             int_ack_o
);
    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    initial begin
        io_addr_o = 16'h0000;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
        int_ack_o = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        io_addr_o = a;
        io_wdata_o = (!a[0] && d[4:3] == 2'h1) ? {1'b0, d[6:0]} : d;
        io_wr_o = 1'b1;
        @(negedge sys_clk_i);
        io_wr_o = 1'b0;
        io_addr_o = ~io_addr_o;
        io_wdata_o = ~io_wdata_o;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk_i);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(negedge sys_clk_i);
        io_rd_o = 1'b0;
        io_addr_o = ~io_addr_o;
        d = io_rdata_i;
        v = io_rdata_valid_i;
    endtask
    task automatic ack();
        @(negedge sys_clk_i);
        int_ack_o = 1'b1;
        @(negedge sys_clk_i);
        int_ack_o = 1'b0;
    endtask
endmodule // ioc_host
`default_nettype wire

// [ioc_pkg.sv]
// Purpose: shared constants for the cascaded interrupt command-word logic
// Assumes: 8-bit I/O data, two controllers, slave cascaded on master input 2
// Notes:   offsets, field positions and codes used by ioc_top, and its byte-wide reset values, live here; the checker and bench repeat some as literals
package ioc_pkg;

    // ------------------------------------------------------------------
    // port map
    // ------------------------------------------------------------------
    localparam logic [15:0] MASTER_CMD_PORT  = 16'h0020;
    localparam logic [15:0] MASTER_MASK_PORT = 16'h0021;
    localparam logic [15:0] SLAVE_CMD_PORT   = 16'h00a0;
    localparam logic [15:0] SLAVE_MASK_PORT  = 16'h00a1;

    // ------------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------------
    localparam int INIT_BIT       = 4;
    localparam int OCW_SEL_BIT    = 3;
    localparam int SMM_ENABLE_BIT = 6;
    localparam int SMM_VALUE_BIT  = 5;
    localparam int POLL_BIT       = 2;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_WHICH_BIT = 0;
    localparam int POLL_PEND_BIT  = 7;
    localparam int CMD_MSB        = 7;
    localparam int CMD_LSB        = 5;
    localparam int CHAN_MSB       = 2;
    localparam int INIT_SINGLE_BIT = 1;
    localparam int INIT_NEED4_BIT  = 0;
    localparam int ICW4_AUTO_BIT   = 1;

    // ------------------------------------------------------------------
    // end-of-service / rotation command codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_CLR_ROT_AUTO  = 3'h0;
    localparam logic [2:0] CMD_NONSPEC_EOS   = 3'h1;
    localparam logic [2:0] CMD_NONE          = 3'h2;
    localparam logic [2:0] CMD_SPEC_EOS      = 3'h3;
    localparam logic [2:0] CMD_SET_ROT_AUTO  = 3'h4;
    localparam logic [2:0] CMD_ROT_NONSPEC   = 3'h5;
    localparam logic [2:0] CMD_SPEC_ROTATE   = 3'h6;
    localparam logic [2:0] CMD_ROT_SPEC_EOS  = 3'h7;

    // ------------------------------------------------------------------
    // reset values and fixed numbers
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [2:0] LOWEST_RESET   = 3'h7;
    localparam logic [2:0] CASCADE_IR     = 3'h2;
    localparam logic [3:0] SLAVE_IRQ_BASE = 4'h8;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;
    localparam int         NUM_UNITS      = 2;

endpackage

// [ioc_prio.sv]
// Purpose: rotating priority resolver for one controller
// Assumes: channel after lowest is highest priority
// Notes:   combinational; caller registers what it needs
`timescale 1ns/1ns
`default_nettype none
module ioc_prio (
    ioc_prio_if.prio p
);
    logic       blocked;
    logic       found;
    logic [2:0] c;

    always_comb begin
        p.pend    = 1'b0;
        p.lvl     = 3'h0;
        p.isr_any = |p.in_service_register;
        p.isr_top = 3'h0;
        blocked   = 1'b0;
        found     = 1'b0;
        c         = 3'h0;
        for (int i = 0; i < 8; i++) begin
            c = 3'(p.lowest + 3'h1 + 3'(i));
            // special mask mode: in-service bits never block
            if (!p.smm && p.in_service_register[c]) begin
                blocked = 1'b1;
            end
            if (!blocked && !p.pend && p.req[c]) begin
                p.pend = 1'b1;
                p.lvl  = c;
            end
            if (!found && p.in_service_register[c]) begin
                found     = 1'b1;
                p.isr_top = c;
            end
        end
    end
endmodule // ioc_prio
`default_nettype wire

// [ioc_prio_if.sv]
// Purpose: carries one controller's state into its priority resolver and back
// Assumes: same clock on both sides, purely combinational path
// Notes:   results are valid in the same cycle as the inputs
`timescale 1ns/1ns
`default_nettype none
interface ioc_prio_if;
    logic [7:0] req;
    logic [7:0] in_service_register;
    logic       smm;
    logic [2:0] lowest;
    logic       pend;
    logic [2:0] lvl;
    logic       isr_any;
    logic [2:0] isr_top;

    modport unit (output req, output in_service_register, output smm, output lowest,
                  input pend, input lvl, input isr_any, input isr_top);
    modport prio (input req, input in_service_register, input smm, input lowest,
                  output pend, output lvl, output isr_any, output isr_top);
endinterface
`default_nettype wire

// [ioc_sync.sv]
// Purpose: two-stage synchroniser for asynchronous request pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module ioc_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // ioc_sync
`default_nettype wire

// [ioc_top.sv]
// Purpose: command-word handling of a cascaded master/slave interrupt pair
// Assumes: host strobes are one-cycle pulses on sys_clk_i; request pins async
// Notes:   inputs are level triggered; init words after the first are consumed
`timescale 1ns/1ns
`default_nettype none
module ioc_top (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic [7:0]  master_irq_i,
    input  wire logic [7:0]  slave_irq_i,
    input  wire logic        int_ack_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_rdata_valid_o,
    output logic             master_int_o,
    output logic      [3:0]  ack_irq_o,
    output logic             ack_valid_o
);
    // ------------------------------------------------------------------
    // request pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0] msync;
    logic [7:0] ssync;

    ioc_sync #(.W(8)) u_msync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (master_irq_i),
        .sync_o    (msync)
    );

    ioc_sync #(.W(8)) u_ssync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (slave_irq_i),
        .sync_o    (ssync)
    );

    // ------------------------------------------------------------------
    // per-controller state
    // ------------------------------------------------------------------
    ioc_prio_if pif [ioc_pkg::NUM_UNITS] ();

    logic [15:0] cmd_port   [ioc_pkg::NUM_UNITS];
    logic [15:0] mask_port  [ioc_pkg::NUM_UNITS];
    logic [7:0]  req_in     [ioc_pkg::NUM_UNITS];
    logic        unit_ack   [ioc_pkg::NUM_UNITS];
    logic [7:0]  rd_even    [ioc_pkg::NUM_UNITS];
    logic [7:0]  rd_odd     [ioc_pkg::NUM_UNITS];
    logic        poll_now   [ioc_pkg::NUM_UNITS];
    logic        unit_pend  [ioc_pkg::NUM_UNITS];
    logic [2:0]  unit_lvl   [ioc_pkg::NUM_UNITS];
    logic        slave_hit;

    assign cmd_port[0]  = ioc_pkg::MASTER_CMD_PORT;
    assign mask_port[0] = ioc_pkg::MASTER_MASK_PORT;
    // slave mask/poll/status word shares the slave command port
    assign cmd_port[1]  = ioc_pkg::SLAVE_CMD_PORT;
    assign mask_port[1] = ioc_pkg::SLAVE_MASK_PORT;

    // slave pending request enters master input 2 (cascade)
    always_comb begin
        req_in[0] = msync;
        req_in[0][ioc_pkg::CASCADE_IR] = msync[ioc_pkg::CASCADE_IR] | unit_pend[1];
        req_in[1] = ssync;
    end

    // slave is only acknowledged when the master picks the cascade input
    assign slave_hit   = unit_pend[0] && (unit_lvl[0] == ioc_pkg::CASCADE_IR);
    assign unit_ack[0] = int_ack_i;
    assign unit_ack[1] = int_ack_i && slave_hit;

    for (genvar u = 0; u < ioc_pkg::NUM_UNITS; u++) begin : g_unit
        logic [7:0] irr_q, irr_d;
        logic [7:0] isr_q, isr_d;
        logic [7:0] mask_q, mask_d;
        logic       smm_q, smm_d;
        logic       poll_q, poll_d;
        logic       sel_isr_q, sel_isr_d;
        logic [2:0] lowest_q, lowest_d;
        logic       rot_auto_q, rot_auto_d;
        logic       auto_q, auto_d;
        logic [1:0] init_cnt_q, init_cnt_d;
        logic       need4_q, need4_d;
        logic       even_wr;
        logic       odd_wr;
        logic       even_rd;
        logic [2:0] chan;

        assign even_wr = io_wr_i && (io_addr_i == cmd_port[u]);
        assign odd_wr  = io_wr_i && (io_addr_i == mask_port[u]);
        assign even_rd = io_rd_i && (io_addr_i == cmd_port[u]);
        assign chan    = io_wdata_i[ioc_pkg::CHAN_MSB:0];

        // mask bits gate requests in every mode
        assign pif[u].req    = irr_q & ~mask_q;
        assign pif[u].in_service_register    = isr_q;
        assign pif[u].smm    = smm_q;
        assign pif[u].lowest = lowest_q;

        ioc_prio u_prio (
            .p (pif[u])
        );

        assign unit_pend[u] = pif[u].pend;
        assign unit_lvl[u]  = pif[u].lvl;
        assign poll_now[u]  = poll_q;
        // poll word: pending flag on top, level in the low bits
        assign rd_even[u]   = poll_q ? {pif[u].pend, 4'h0, pif[u].lvl} :
                              (sel_isr_q ? isr_q : irr_q);
        assign rd_odd[u]    = mask_q;

        always_comb begin
            // request register holds while a poll is outstanding
            irr_d      = poll_q ? irr_q : req_in[u];
            isr_d      = isr_q;
            mask_d     = mask_q;
            smm_d      = smm_q;
            poll_d     = poll_q;
            sel_isr_d  = sel_isr_q;
            lowest_d   = lowest_q;
            rot_auto_d = rot_auto_q;
            auto_d     = auto_q;
            init_cnt_d = init_cnt_q;
            need4_d    = need4_q;
            // bit 7 is decoded only as the top bit of the end-of-service/rotation command code
            if (even_wr) begin
                if (io_wdata_i[ioc_pkg::INIT_BIT]) begin
                    // first init word: restart and count following words
                    mask_d     = ioc_pkg::MASK_RESET;
                    isr_d      = ioc_pkg::REG_RESET;
                    smm_d      = 1'b0;
                    poll_d     = 1'b0;
                    sel_isr_d  = 1'b0;
                    lowest_d   = ioc_pkg::LOWEST_RESET;
                    rot_auto_d = 1'b0;
                    auto_d     = 1'b0;
                    need4_d    = io_wdata_i[ioc_pkg::INIT_NEED4_BIT];
                    init_cnt_d = 2'h1
                               + {1'b0, ~io_wdata_i[ioc_pkg::INIT_SINGLE_BIT]}
                               + {1'b0, io_wdata_i[ioc_pkg::INIT_NEED4_BIT]};
                end else if (io_wdata_i[ioc_pkg::OCW_SEL_BIT]) begin
                    if (io_wdata_i[ioc_pkg::SMM_ENABLE_BIT]) begin
                        smm_d = io_wdata_i[ioc_pkg::SMM_VALUE_BIT];
                    end
                    if (io_wdata_i[ioc_pkg::POLL_BIT]) begin
                        poll_d = 1'b1;
                    end
                    if (io_wdata_i[ioc_pkg::STAT_VALID_BIT]) begin
                        sel_isr_d = io_wdata_i[ioc_pkg::STAT_WHICH_BIT];
                    end
                end else begin
                    // channel field only used by specific codes
                    unique case (io_wdata_i[ioc_pkg::CMD_MSB:ioc_pkg::CMD_LSB])
                        ioc_pkg::CMD_CLR_ROT_AUTO: begin
                            rot_auto_d = 1'b0;
                        end
                        ioc_pkg::CMD_NONSPEC_EOS: begin
                            if (pif[u].isr_any) begin
                                isr_d[pif[u].isr_top] = 1'b0;
                            end
                        end
                        ioc_pkg::CMD_NONE: begin
                            isr_d = isr_q;
                        end
                        ioc_pkg::CMD_SPEC_EOS: begin
                            isr_d[chan] = 1'b0;
                        end
                        ioc_pkg::CMD_SET_ROT_AUTO: begin
                            rot_auto_d = 1'b1;
                        end
                        ioc_pkg::CMD_ROT_NONSPEC: begin
                            if (pif[u].isr_any) begin
                                isr_d[pif[u].isr_top] = 1'b0;
                                lowest_d = pif[u].isr_top;
                            end
                        end
                        ioc_pkg::CMD_SPEC_ROTATE: begin
                            lowest_d = chan;
                        end
                        ioc_pkg::CMD_ROT_SPEC_EOS: begin
                            isr_d[chan] = 1'b0;
                            lowest_d    = chan;
                        end
                    endcase
                end
            end
            if (odd_wr) begin
                if (init_cnt_q != 2'h0) begin
                    // later init words are consumed; only auto end-of-service kept
                    init_cnt_d = init_cnt_q - 2'h1;
                    if (need4_q && (init_cnt_q == 2'h1)) begin
                        auto_d = io_wdata_i[ioc_pkg::ICW4_AUTO_BIT];
                    end
                end else begin
                    mask_d = io_wdata_i;
                end
            end
            // poll read or acknowledge moves the winner into service unless auto end-of-service is set
            if ((even_rd && poll_q) || unit_ack[u]) begin
                if (pif[u].pend) begin
                    if (!auto_q) begin
                        isr_d[pif[u].lvl] = 1'b1;
                    end else if (rot_auto_q) begin
                        lowest_d = pif[u].lvl;
                    end
                end
            end
            if (even_rd && poll_q) begin
                poll_d = 1'b0;
            end
        end

        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                // command fields start at zero except lowest at 7, inputs unmasked
                irr_q      <= ioc_pkg::REG_RESET;
                isr_q      <= ioc_pkg::REG_RESET;
                mask_q     <= ioc_pkg::MASK_RESET;
                smm_q      <= 1'b0;
                poll_q     <= 1'b0;
                sel_isr_q  <= 1'b0;
                lowest_q   <= ioc_pkg::LOWEST_RESET;
                rot_auto_q <= 1'b0;
                auto_q     <= 1'b0;
                init_cnt_q <= 2'h0;
                need4_q    <= 1'b0;
            end else begin
                irr_q      <= irr_d;
                isr_q      <= isr_d;
                mask_q     <= mask_d;
                smm_q      <= smm_d;
                poll_q     <= poll_d;
                sel_isr_q  <= sel_isr_d;
                lowest_q   <= lowest_d;
                rot_auto_q <= rot_auto_d;
                auto_q     <= auto_d;
                init_cnt_q <= init_cnt_d;
                need4_q    <= need4_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // read data, interrupt and acknowledge outputs
    // ------------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;
    logic       int_q, int_d;
    logic [3:0] ack_irq_q, ack_irq_d;
    logic       ack_valid_q, ack_valid_d;

    always_comb begin
        rdata_d     = ioc_pkg::UNMAPPED_READ;
        rvalid_d    = io_rd_i;
        int_d       = unit_pend[0];
        ack_irq_d   = ack_irq_q;
        ack_valid_d = 1'b0;
        if (io_rd_i) begin
            for (int u = 0; u < ioc_pkg::NUM_UNITS; u++) begin
                if (io_addr_i == cmd_port[u]) begin
                    rdata_d = rd_even[u];
                end else if (io_addr_i == mask_port[u]) begin
                    rdata_d = rd_odd[u];
                end
            end
        end
        if (int_ack_i && unit_pend[0]) begin
            ack_valid_d = 1'b1;
            // slave channel n reports as system request 8+n
            ack_irq_d   = (slave_hit && unit_pend[1]) ?
                          ioc_pkg::SLAVE_IRQ_BASE + {1'b0, unit_lvl[1]} :
                          {1'b0, unit_lvl[0]};
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q     <= ioc_pkg::REG_RESET;
            rvalid_q    <= 1'b0;
            int_q       <= 1'b0;
            ack_irq_q   <= 4'h0;
            ack_valid_q <= 1'b0;
        end else begin
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            int_q       <= int_d;
            ack_irq_q   <= ack_irq_d;
            ack_valid_q <= ack_valid_d;
        end
    end

    assign io_rdata_o       = rdata_q;
    assign io_rdata_valid_o = rvalid_q;
    assign master_int_o     = int_q;
    assign ack_irq_o        = ack_irq_q;
    assign ack_valid_o      = ack_valid_q;
endmodule // ioc_top
`default_nettype wire

// [ioc_top_sva.sv]
// Purpose: port-level checker for the interrupt command-word block
// Assumes: strobes are single-cycle pulses on sys_clk_i
// Notes:   register checks on slave mask and command ports only; master poll not watched
`timescale 1ns/1ns
`default_nettype none
module ioc_top_sva (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        int_ack_i,
    input  wire logic [7:0]  io_rdata_o,
    input  wire logic        io_rdata_valid_o,
    input  wire logic [3:0]  ack_irq_o,
    input  wire logic        ack_valid_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic mapped;
    logic wr_cmd;
    logic rd_cmd;
    logic rd_msk;
    assign mapped = io_addr_i inside {ioc_pkg::MASTER_CMD_PORT, ioc_pkg::MASTER_MASK_PORT,
                                      ioc_pkg::SLAVE_CMD_PORT, ioc_pkg::SLAVE_MASK_PORT};
    assign wr_cmd = io_wr_i && io_addr_i == ioc_pkg::SLAVE_CMD_PORT;
    assign rd_cmd = io_rd_i && io_addr_i == ioc_pkg::SLAVE_CMD_PORT;
    assign rd_msk = io_rd_i && io_addr_i == ioc_pkg::SLAVE_MASK_PORT;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_rd_lat; io_rd_i |=> io_rdata_valid_o; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_only; !io_rd_i |=> !io_rdata_valid_o; endproperty
    a_rd_only: assert property (p_rd_only) else $error("valid without read");
    property p_idle_zero; !io_rdata_valid_o |-> io_rdata_o == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not cleared");
    property p_unmapped; io_rd_i && !mapped |=> io_rdata_o == ioc_pkg::UNMAPPED_READ; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
    property p_mask_rb;
        io_wr_i && io_addr_i == ioc_pkg::SLAVE_MASK_PORT ##2 rd_msk
            |=> io_rdata_o == $past(io_wdata_i, 3);
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_init_clr; wr_cmd && io_wdata_i[4] ##2 rd_msk |=> io_rdata_o == 8'h00; endproperty
    a_init_clr: assert property (p_init_clr) else $error("init left mask");
    property p_poll_fmt;
        wr_cmd && io_wdata_i[4:2] == 3'h3 ##2 rd_cmd |=> io_rdata_o[6:3] == 4'h0;
    endproperty
    a_poll_fmt: assert property (p_poll_fmt) else $error("poll word format");
    property p_ack_cause; ack_valid_o |-> $past(int_ack_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_hold; !ack_valid_o |-> $stable(ack_irq_o); endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack level moved");
endmodule // ioc_top_sva
bind ioc_top ioc_top_sva u_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .int_ack_i(int_ack_i), .io_rdata_o(io_rdata_o), .io_rdata_valid_o(io_rdata_valid_o),
    .ack_irq_o(ack_irq_o), .ack_valid_o(ack_valid_o));
`default_nettype wire

// [ioc_top_tb.sv]
// Purpose: self-checking bench for the interrupt command-word block
// Assumes: slave controller exercised; master carries the cascade and one special-mask poll
// Notes:   request pins need three cycles to reach the request register
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module ioc_top_tb;
    logic        sys_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic        int_ack;
    logic [7:0]  master_irq = 8'h00;
    logic [7:0]  slave_irq = 8'h00;
    logic [7:0]  io_rdata_o;
    logic        io_rdata_valid_o;
    logic        master_int_o;
    logic [3:0]  ack_irq_o;
    logic        ack_valid_o;
    int          num_errors = 0;
    int          check_count = 0;
    localparam logic [15:0] SCP = ioc_pkg::SLAVE_CMD_PORT;
    localparam logic [15:0] SMP = ioc_pkg::SLAVE_MASK_PORT;
    always #10 sys_clk_i = ~sys_clk_i;
    ioc_host host (.sys_clk_i(sys_clk_i), .io_rdata_i(io_rdata_o),
        .io_rdata_valid_i(io_rdata_valid_o), .io_addr_o(io_addr), .io_wr_o(io_wr),
        .io_rd_o(io_rd), .io_wdata_o(io_wdata), .int_ack_o(int_ack));
    ioc_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .io_addr_i(io_addr),
        .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .master_irq_i(master_irq),
        .slave_irq_i(slave_irq), .int_ack_i(int_ack), .io_rdata_o(io_rdata_o),
        .io_rdata_valid_o(io_rdata_valid_o), .master_int_o(master_int_o),
        .ack_irq_o(ack_irq_o), .ack_valid_o(ack_valid_o));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        logic       v;
        host.rd(a, d, v);
        `CHK(n, {1'b1, e}, {v, d})
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdchk(SMP, ioc_pkg::MASK_RESET, "mask_rst");
        rdchk(SCP, ioc_pkg::REG_RESET, "irr_rst");
        rdchk(16'h0030, ioc_pkg::UNMAPPED_READ, "unmapped");
        host.ack();
        `CHK("no_ack", 1'b0, ack_valid_o)
        $display("done t_reset");
    endtask
    task automatic t_mask();
        host.wr(SMP, 8'ha5);
        rdchk(SMP, 8'ha5, "mask");
        host.wr(SCP, 8'h11);
        rdchk(SMP, ioc_pkg::MASK_RESET, "mask_init");
        host.wr(SMP, 8'h70);
        host.wr(SMP, 8'h02);
        host.wr(SMP, 8'h01);
        host.wr(SMP, 8'h3c);
        rdchk(SMP, 8'h3c, "mask_after_init");
        host.wr(SMP, 8'h00);
        $display("done t_mask");
    endtask
    task automatic t_poll();
        slave_irq = 8'h28;
        repeat (4) @(negedge sys_clk_i);
        host.wr(SCP, 8'h0c);
        slave_irq = 8'h2c;
        repeat (4) @(negedge sys_clk_i);
        slave_irq = 8'h28;
        rdchk(SCP, 8'h83, "poll");
        rdchk(SCP, 8'h28, "irr_after_poll");
        host.wr(SCP, 8'h0b);
        rdchk(SCP, 8'h08, "isr");
        host.wr(SCP, 8'h09);
        rdchk(SCP, 8'h08, "isr_kept");
        $display("done t_poll");
    endtask
    task automatic t_smm();
        logic [7:0] d;
        logic       v;
        host.wr(SCP, 8'h28);
        host.wr(SCP, 8'h0c);
        host.rd(SCP, d, v);
        `CHK("smm_locked", 1'b0, d[7])
        host.wr(SCP, 8'h68);
        host.wr(SMP, 8'h08);
        host.wr(SCP, 8'h0c);
        rdchk(SCP, 8'h85, "smm_poll");
        host.wr(SMP, 8'h00);
        host.wr(SCP, 8'h48);
        $display("done t_smm");
    endtask
    task automatic t_eoi();
        rdchk(SCP, 8'h28, "isr_both");
        host.wr(SCP, 8'h43);
        rdchk(SCP, 8'h28, "no_cmd");
        host.wr(SCP, 8'h65);
        rdchk(SCP, 8'h08, "spec_eos");
        host.wr(SCP, 8'h20);
        rdchk(SCP, 8'h00, "nonspec_eos");
        host.wr(SCP, 8'h80);
        host.wr(SCP, 8'h00);
        rdchk(SCP, 8'h00, "auto_rot");
        host.wr(SCP, 8'hc3);
        host.wr(SCP, 8'h0c);
        rdchk(SCP, 8'h85, "spec_rot");
        host.wr(SCP, 8'he5);
        rdchk(SCP, 8'h00, "rot_spec_eos");
        host.wr(SCP, 8'h0c);
        rdchk(SCP, 8'h83, "poll_rot");
        host.wr(SCP, 8'ha0);
        rdchk(SCP, 8'h00, "rot_nonspec");
        $display("done t_eoi");
    endtask
    task automatic t_ack();
        `CHK("cascade_int", 1'b1, master_int_o)
        host.ack();
        `CHK("ack_valid", 1'b1, ack_valid_o)
        `CHK("ack_level", 4'hd, ack_irq_o)
        // master: in-service cascade bit must not block once special mask is on
        master_irq = 8'h10;
        repeat (4) @(negedge sys_clk_i);
        host.wr(16'h0020, 8'h6c);
        rdchk(16'h0020, 8'h84, "master_poll");
        $display("done t_ack");
    endtask
    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge sys_clk_i);
        reset_i = 1'b0;
        t_reset();
        t_mask();
        t_poll();
        t_smm();
        t_eoi();
        t_ack();
        stop_test();
    end
    initial begin
        #(20 * 5000);
        num_errors++;
        stop_test();
    end
endmodule // ioc_top_tb
`default_nettype wire
